// ---- hw/qepoll_pkg.sv ----
// types shared by the status poller files
package qepoll_pkg;

  // poll sequencer states, one-hot
  typedef enum logic [4:0] {
    QEP_IDLE = 5'b00001,
    QEP_WAIT = 5'b00010,
    QEP_OPC = 5'b00100,
    QEP_RECV = 5'b01000,
    QEP_DONE = 5'b10000
  } qepoll_state_e;

  // serial lane modes
  typedef enum logic [1:0] {
    QEP_LANE_SINGLE = 2'b00,
    QEP_LANE_DUAL = 2'b01,
    QEP_LANE_QUAD = 2'b10,
    QEP_LANE_RSVD = 2'b11
  } qepoll_lane_e;

  typedef logic [7:0] qepoll_byte_t;

endpackage

// ---- hw/qepoll_regs.svh ----
// register offsets, field positions, reset values and timing counts of the status poller
`ifndef QEPOLL_REGS_SVH
`define QEPOLL_REGS_SVH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define QEP_OFF_CMD 32'h0c000034
`define QEP_OFF_TRIG 32'h0c000038
`define QEP_OFF_PAD 32'h0c00003c
`define QEP_OFF_AUX 32'h0c000040

// ----------------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------------
`define QEP_CMD_RESET 32'h00000000
`define QEP_PAD_RESET 32'h00000000
`define QEP_AUX_RESET 32'h00000000
`define QEP_CMD_MASK 32'h007fffff
`define QEP_PAD_MASK 32'h0000001e
`define QEP_AUX_MASK 32'h0000003f

// ----------------------------------------------------------------------
// status_poll_command fields
// ----------------------------------------------------------------------
`define QEP_CMD_SEL 22
`define QEP_CMD_DLY_HI 21
`define QEP_CMD_DLY_LO 16
`define QEP_CMD_BUSYVAL 15
`define QEP_CMD_POS_HI 14
`define QEP_CMD_POS_LO 12
`define QEP_CMD_RX_HI 11
`define QEP_CMD_RX_LO 10
`define QEP_CMD_TX_HI 9
`define QEP_CMD_TX_LO 8
`define QEP_CMD_OP_HI 7
`define QEP_CMD_OP_LO 0

// ----------------------------------------------------------------------
// serial_pad_settings and slow delay / status fields
// ----------------------------------------------------------------------
`define QEP_PAD_SLEW_HI 4
`define QEP_PAD_SLEW_LO 3
`define QEP_PAD_DRV_HI 2
`define QEP_PAD_DRV_LO 1
`define QEP_AUX_DLY_HI 5
`define QEP_AUX_DLY_LO 0
`define QEP_AUX_FLAG 8
`define QEP_AUX_STS_HI 23
`define QEP_AUX_STS_LO 16

// ----------------------------------------------------------------------
// timing: serial clock half period derived from the system clock period
// ----------------------------------------------------------------------
`define QEP_HCLK_PERIOD_NS 4
`define QEP_SCLK_HALF_NS 16
`define QEP_SCLK_HALF_CYC ((`QEP_SCLK_HALF_NS + `QEP_HCLK_PERIOD_NS - 1) / `QEP_HCLK_PERIOD_NS)

`endif

// ---- hw/qepoll_slow_edge.sv ----
// synchroniser and rising-edge detector for the slow 222 kHz clock
`timescale 1ns/10ps
module qepoll_slow_edge (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic slow_clk,
  output logic rise_pulse
);

  logic sync1_reg;
  logic sync2_reg;
  logic last_reg;
  logic rise_reg;

  // two flops for the foreign clock, then a third for edge finding
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg <= 1'b0;
      rise_reg <= 1'b0;
    end else begin
      sync1_reg <= slow_clk;
      sync2_reg <= sync1_reg;
      last_reg <= sync2_reg;
      rise_reg <= sync2_reg & ~last_reg;
    end
  end

  assign rise_pulse = rise_reg;

endmodule // qepoll_slow_edge

// ---- hw/qepoll_top.sv ----
// post-erase flash status poller with its register slave
//
// How it works
// - selector bit picks serial-clock delay field or slow 222 kHz delay counter.
// - zero delay starts the status read at once.
// - nonzero delay waits at least that many serial clocks, or slow clocks when selected, after erase ends.
// - busy polarity bit says which status bit value means busy.
// - three-bit field picks which status byte bit is busy.
// - status byte is received in single, dual or quad lane mode.
// - opcode is sent in its own single, dual or quad lane mode.
// - programmable eight-bit opcode is sent in every status read.
// - writing the trigger register during erase forces a status read.
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/10ps
`include "qepoll_regs.svh"
module qepoll_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic erase_cmd_start,
  input wire logic erase_cmd_done,
  input wire logic slow_clk,
  output logic qspi_sclk,
  output logic qspi_cs_n,
  output logic [3:0] qspi_io_out,
  output logic [3:0] qspi_io_oe,
  input wire logic [3:0] qspi_io_in,
  output logic erase_in_progress,
  output logic [1:0] pad_slew_select,
  output logic [1:0] pad_drive_select
);
  import qepoll_pkg::*;

  // ----------------------------------------------------------------------
  // lane helpers
  // ----------------------------------------------------------------------
  function automatic logic [3:0] lane_width(input logic [1:0] m);
    case (m)
      QEP_LANE_DUAL: lane_width = 4'h2;
      QEP_LANE_QUAD: lane_width = 4'h4;
      default: lane_width = 4'h1;
    endcase
  endfunction

  function automatic logic [3:0] lane_clocks(input logic [1:0] m);
    case (m)
      QEP_LANE_DUAL: lane_clocks = 4'h4;
      QEP_LANE_QUAD: lane_clocks = 4'h2;
      default: lane_clocks = 4'h8;
    endcase
  endfunction

  // top bits of the byte mapped onto the lanes
  function automatic logic [3:0] lane_out(input logic [7:0] b, input logic [1:0] m);
    case (m)
      QEP_LANE_DUAL: lane_out = {2'b00, b[7:6]};
      QEP_LANE_QUAD: lane_out = b[7:4];
      default: lane_out = {3'b000, b[7]};
    endcase
  endfunction

  function automatic logic [3:0] lane_oe(input logic [1:0] m);
    case (m)
      QEP_LANE_DUAL: lane_oe = 4'h3;
      QEP_LANE_QUAD: lane_oe = 4'hf;
      default: lane_oe = 4'h1;
    endcase
  endfunction

  // single mode reads the flash output on lane 1
  function automatic logic [7:0] lane_in(input logic [7:0] r, input logic [3:0] io,
                                         input logic [1:0] m);
    case (m)
      QEP_LANE_DUAL: lane_in = {r[5:0], io[1:0]};
      QEP_LANE_QUAD: lane_in = {r[3:0], io[3:0]};
      default: lane_in = {r[6:0], io[1]};
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [31:0] cmd_reg;
  logic [31:0] pad_reg;
  logic [31:0] aux_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic rd_pend_reg;
  logic [7:0] rd_addr_reg;
  logic hreadyout_reg;
  logic [31:0] hrdata_reg;
  logic hresp_reg;
  logic [31:0] rd_mux;
  logic ahb_take;
  logic trig_wr;
  logic trig_pend_reg;
  logic flag_reg;
  qepoll_state_e state_reg;
  logic [2:0] div_cnt_reg;
  logic half_tick;
  logic slow_tick;
  logic [6:0] dly_cnt_reg;
  logic sel_reg;
  logic [5:0] dly_val_reg;
  logic [1:0] tx_mode_reg;
  logic [1:0] rx_mode_reg;
  logic [2:0] pos_reg;
  logic pol_reg;
  logic [7:0] tx_shift_reg;
  qepoll_byte_t rx_reg;
  logic [3:0] clk_left_reg;
  logic sclk_reg;
  logic cs_n_reg;
  logic [3:0] io_out_reg;
  logic [3:0] io_oe_reg;
  logic [3:0] io_s1_reg;
  logic [3:0] io_s2_reg;
  logic start_req;
  logic delay_zero;
  logic wait_done;
  logic go_opc;
  logic busy_now;
  logic [5:0] cur_dly;

  // ----------------------------------------------------------------------
  // bus slave: writes complete in zero wait states, reads take one
  // ----------------------------------------------------------------------
  assign ahb_take = hsel & htrans[1] & hready & (hsize == 3'b010);

  // read data is registered, so a read that follows a write sees the new value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= 8'h00;
      hreadyout_reg <= 1'b1;
      hrdata_reg <= 32'h00000000;
      hresp_reg <= 1'b0;
    end else begin
      wr_pend_reg <= ahb_take & hwrite;
      if (ahb_take) begin
        wr_addr_reg <= haddr[7:0];
        rd_addr_reg <= haddr[7:0];
      end
      if (ahb_take && !hwrite) begin
        rd_pend_reg <= 1'b1;
        hreadyout_reg <= 1'b0;
      end else if (rd_pend_reg) begin
        rd_pend_reg <= 1'b0;
        hreadyout_reg <= 1'b1;
        hrdata_reg <= rd_mux;
      end
    end
  end

  // read view; the trigger and unmapped words read as zero
  always_comb begin
    rd_mux = 32'h00000000;
    case (rd_addr_reg)
      8'(`QEP_OFF_CMD): rd_mux = cmd_reg;
      8'(`QEP_OFF_PAD): rd_mux = pad_reg;
      8'(`QEP_OFF_AUX): begin
        rd_mux = aux_reg;
        rd_mux[`QEP_AUX_FLAG] = flag_reg;
        rd_mux[`QEP_AUX_STS_HI:`QEP_AUX_STS_LO] = rx_reg;
      end
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_reg <= `QEP_CMD_RESET;
      pad_reg <= `QEP_PAD_RESET;
      aux_reg <= `QEP_AUX_RESET;
    end else if (wr_pend_reg) begin
      if (wr_addr_reg == 8'(`QEP_OFF_CMD)) cmd_reg <= hwdata & `QEP_CMD_MASK;
      if (wr_addr_reg == 8'(`QEP_OFF_PAD)) pad_reg <= hwdata & `QEP_PAD_MASK;
      if (wr_addr_reg == 8'(`QEP_OFF_AUX)) aux_reg <= hwdata & `QEP_AUX_MASK;
    end
  end

  // ----------------------------------------------------------------------
  // erase-check trigger and the erase-in-progress flag
  // ----------------------------------------------------------------------
  assign trig_wr = wr_pend_reg & (wr_addr_reg == 8'(`QEP_OFF_TRIG));
  assign busy_now = (rx_reg[pos_reg] == pol_reg);

  // a trigger outside an erase is dropped; a new one wins over consumption
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_pend_reg <= 1'b0;
    end else if (trig_wr && flag_reg) begin
      trig_pend_reg <= 1'b1;
    end else if (!flag_reg || (state_reg == QEP_IDLE && !erase_cmd_done)) begin
      trig_pend_reg <= 1'b0;
    end
  end

  // the erase start wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_reg <= 1'b0;
    end else if (erase_cmd_start) begin
      flag_reg <= 1'b1;
    end else if (state_reg == QEP_DONE && !busy_now) begin
      flag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // serial clock divider and input synchronisers
  // ----------------------------------------------------------------------
  // held at zero in idle so the first serial half period is always full
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_reg <= 3'h0;
    end else if (state_reg == QEP_IDLE || half_tick) begin
      div_cnt_reg <= 3'h0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 3'h1;
    end
  end

  assign half_tick = (div_cnt_reg == 3'(`QEP_SCLK_HALF_CYC - 1));

  // flash data lines are foreign to this clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      io_s1_reg <= 4'h0;
      io_s2_reg <= 4'h0;
    end else begin
      io_s1_reg <= qspi_io_in;
      io_s2_reg <= io_s1_reg;
    end
  end

  qepoll_slow_edge u_slow_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .slow_clk(slow_clk),
    .rise_pulse(slow_tick)
  );

  // ----------------------------------------------------------------------
  // poll sequencer
  // ----------------------------------------------------------------------
  assign cur_dly = cmd_reg[`QEP_CMD_SEL] ? aux_reg[`QEP_AUX_DLY_HI:`QEP_AUX_DLY_LO]
                                         : cmd_reg[`QEP_CMD_DLY_HI:`QEP_CMD_DLY_LO];
  assign delay_zero = (cur_dly == 6'h00) || (trig_pend_reg && !erase_cmd_done);
  assign start_req = erase_cmd_done | (trig_pend_reg & flag_reg);
  // qspi mode counts serial halves, so 2n halves is n whole clocks
  assign wait_done = sel_reg ? (dly_cnt_reg > {1'b0, dly_val_reg})
                             : (dly_cnt_reg >= {dly_val_reg, 1'b0});
  assign go_opc = (state_reg == QEP_IDLE && start_req && delay_zero)
                  || (state_reg == QEP_WAIT && wait_done && half_tick);

  // settings are latched at the start, but the opcode and its first lane mode and clock count are read from cmd_reg when the opcode phase starts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_reg <= 1'b0;
      dly_val_reg <= 6'h00;
      tx_mode_reg <= 2'b00;
      rx_mode_reg <= 2'b00;
      pos_reg <= 3'h0;
      pol_reg <= 1'b0;
    end else if (state_reg == QEP_IDLE && start_req) begin
      sel_reg <= cmd_reg[`QEP_CMD_SEL];
      dly_val_reg <= cur_dly;
      tx_mode_reg <= cmd_reg[`QEP_CMD_TX_HI:`QEP_CMD_TX_LO];
      rx_mode_reg <= cmd_reg[`QEP_CMD_RX_HI:`QEP_CMD_RX_LO];
      pos_reg <= cmd_reg[`QEP_CMD_POS_HI:`QEP_CMD_POS_LO];
      pol_reg <= cmd_reg[`QEP_CMD_BUSYVAL];
    end
  end

  // one frame: opcode out, status byte in; data changes on falling sclk
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= QEP_IDLE;
      dly_cnt_reg <= 7'h00;
      tx_shift_reg <= 8'h00;
      rx_reg <= 8'h00;
      clk_left_reg <= 4'h0;
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      io_out_reg <= 4'h0;
      io_oe_reg <= 4'h0;
    end else if (go_opc) begin
      state_reg <= QEP_OPC;
      cs_n_reg <= 1'b0;
      sclk_reg <= 1'b0;
      io_out_reg <= lane_out(cmd_reg[`QEP_CMD_OP_HI:`QEP_CMD_OP_LO],
                             cmd_reg[`QEP_CMD_TX_HI:`QEP_CMD_TX_LO]);
      io_oe_reg <= lane_oe(cmd_reg[`QEP_CMD_TX_HI:`QEP_CMD_TX_LO]);
      tx_shift_reg <= cmd_reg[`QEP_CMD_OP_HI:`QEP_CMD_OP_LO]
                      << lane_width(cmd_reg[`QEP_CMD_TX_HI:`QEP_CMD_TX_LO]);
      clk_left_reg <= lane_clocks(cmd_reg[`QEP_CMD_TX_HI:`QEP_CMD_TX_LO]);
    end else begin
      case (state_reg)
        QEP_IDLE: begin
          if (start_req) begin
            state_reg <= QEP_WAIT;
            dly_cnt_reg <= 7'h00;
          end
        end
        QEP_WAIT: begin
          // the slow clock only advances on its synchronised rising edge
          if (sel_reg ? slow_tick : half_tick) begin
            dly_cnt_reg <= dly_cnt_reg + 7'h01;
          end
        end
        QEP_OPC: begin
          if (half_tick) begin
            if (!sclk_reg) begin
              sclk_reg <= 1'b1;
            end else begin
              sclk_reg <= 1'b0;
              if (clk_left_reg == 4'h1) begin
                state_reg <= QEP_RECV;
                io_oe_reg <= 4'h0;
                clk_left_reg <= lane_clocks(rx_mode_reg);
              end else begin
                clk_left_reg <= clk_left_reg - 4'h1;
                io_out_reg <= lane_out(tx_shift_reg, tx_mode_reg);
                tx_shift_reg <= tx_shift_reg << lane_width(tx_mode_reg);
              end
            end
          end
        end
        QEP_RECV: begin
          if (half_tick) begin
            if (!sclk_reg) begin
              sclk_reg <= 1'b1;
            end else begin
              // sampled late in the high half to cover the synchroniser delay
              sclk_reg <= 1'b0;
              rx_reg <= lane_in(rx_reg, io_s2_reg, rx_mode_reg);
              if (clk_left_reg == 4'h1) begin
                state_reg <= QEP_DONE;
              end else begin
                clk_left_reg <= clk_left_reg - 4'h1;
              end
            end
          end
        end
        QEP_DONE: begin
          cs_n_reg <= 1'b1;
          state_reg <= QEP_IDLE;
        end
        default: begin
          state_reg <= QEP_IDLE;
          cs_n_reg <= 1'b1;
          io_oe_reg <= 4'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign hreadyout = hreadyout_reg;
  assign hrdata = hrdata_reg;
  assign hresp = hresp_reg;
  assign qspi_sclk = sclk_reg;
  assign qspi_cs_n = cs_n_reg;
  assign qspi_io_out = io_out_reg;
  assign qspi_io_oe = io_oe_reg;
  assign erase_in_progress = flag_reg;
  assign pad_slew_select = pad_reg[`QEP_PAD_SLEW_HI:`QEP_PAD_SLEW_LO];
  assign pad_drive_select = pad_reg[`QEP_PAD_DRV_HI:`QEP_PAD_DRV_LO];

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_zero_delay_go: assert property ((state_reg == QEP_IDLE && erase_cmd_done
      && cur_dly == 6'h00) |=> (state_reg == QEP_OPC && !qspi_cs_n))
    else $error("zero delay did not start the status read at once");

  a_wait_min_clocks: assert property ((state_reg == QEP_WAIT && !sel_reg && go_opc)
      |-> (dly_cnt_reg >= {dly_val_reg, 1'b0}))
    else $error("status read began before the serial delay elapsed");

  a_slow_counter_hold: assert property ((state_reg == QEP_WAIT && sel_reg
      && !slow_tick && !go_opc) |=> (dly_cnt_reg == $past(dly_cnt_reg)))
    else $error("slow delay counter moved without a slow clock edge");

  a_busy_clears_flag: assert property ((state_reg == QEP_DONE && !busy_now
      && !erase_cmd_start) |=> !erase_in_progress)
    else $error("idle status did not clear the erase flag");

  a_busy_keeps_flag: assert property ((state_reg == QEP_DONE
      && rx_reg[pos_reg] == pol_reg && erase_in_progress) |=> erase_in_progress)
    else $error("busy status cleared the erase flag");

  a_rx_lanes_float: assert property ((state_reg == QEP_RECV) |-> (qspi_io_oe == 4'h0))
    else $error("lanes driven during status receive");

  a_tx_lane_drive: assert property ((state_reg == QEP_OPC
      && tx_mode_reg == QEP_LANE_QUAD) |-> (qspi_io_oe == 4'hf && !qspi_cs_n))
    else $error("quad opcode phase not driving all lanes");

  a_opcode_first_bit: assert property ((state_reg == QEP_OPC
      && $past(state_reg) != QEP_OPC && $past(cmd_reg[9:8]) == 2'b00)
      |-> (qspi_io_out[0] == $past(cmd_reg[7])))
    else $error("first opcode bit does not match the programmed opcode");

  a_trigger_polls: assert property ((trig_wr && flag_reg && state_reg == QEP_IDLE
      && !erase_cmd_done) |-> ##[1:2] (state_reg == QEP_OPC))
    else $error("trigger write did not start a status read");

  a_sclk_low_idle: assert property ((state_reg == QEP_IDLE) |-> (!qspi_sclk && qspi_cs_n))
    else $error("serial clock or select active while idle");

  c_zero_delay_poll: cover property ((state_reg == QEP_IDLE && cur_dly == 6'h00
      && erase_cmd_done) ##1 (state_reg == QEP_OPC));
  c_slow_delay_poll: cover property ((state_reg == QEP_WAIT && sel_reg) ##[1:1000] (state_reg == QEP_OPC));
  c_trigger_poll: cover property (trig_wr && flag_reg ##[1:300] (state_reg == QEP_DONE));
  c_flag_cleared: cover property ((state_reg == QEP_DONE && !busy_now) ##1 !erase_in_progress);

endmodule // qepoll_top

// ---- verification/qepoll_flash_model.sv ----
// behavioural serial flash that logs the opcode and returns a status byte
`timescale 1ns/10ps
module qepoll_flash_model (
  input wire logic qspi_sclk,
  input wire logic qspi_cs_n,
  input wire logic [3:0] qspi_io_out,
  input wire logic [1:0] tx_mode,
  input wire logic [1:0] rx_mode,
  input wire logic [7:0] status,
  output logic [7:0] opcode,
  output logic [3:0] drive
);
  int k = 0;
  logic [7:0] sh;
  // reserved lane mode falls back to one lane
  function automatic int wd(input logic [1:0] m);
    return (m == 2'b10) ? 4 : ((m == 2'b01) ? 2 : 1);
  endfunction
  initial begin
    opcode = 8'h00;
    drive = 4'h5;
  end
  // a new frame restarts the count and reloads the status byte
  always @(negedge qspi_cs_n) begin
    k = 0;
    sh = status;
  end
  // released lines show the inverse of the last value, not a stale copy
  always @(posedge qspi_cs_n) drive = ~drive;
  // opcode bits are taken on rising edges, msb first
  always @(posedge qspi_sclk) begin
    if (!qspi_cs_n && k < 8 / wd(tx_mode)) begin
      case (wd(tx_mode))
        4: opcode = {opcode[3:0], qspi_io_out};
        2: opcode = {opcode[5:0], qspi_io_out[1:0]};
        default: opcode = {opcode[6:0], qspi_io_out[0]};
      endcase
    end
    k++;
  end
  // status moves on falling edges so it is steady across the next sample
  always @(negedge qspi_sclk) begin
    if (!qspi_cs_n && k >= 8 / wd(tx_mode)) begin
      case (wd(rx_mode))
        4: drive = sh[7:4];
        2: drive = {2'b00, sh[7:6]};
        default: drive = {2'b00, sh[7], 1'b0};
      endcase
      sh = sh << wd(rx_mode);
    end
  end
endmodule // qepoll_flash_model

// ---- verification/qepoll_top_test.sv ----
// self-checking bench for the post-erase status poller
`timescale 1ns/10ps
`include "qepoll_regs.svh"
module qepoll_top_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic erase_cmd_start = 1'b0;
  logic erase_cmd_done = 1'b0;
  logic slow_clk = 1'b0;
  logic [7:0] fl_status = 8'h00;
  logic [31:0] cmd = 32'h0;
  logic [5:0] aux = 6'h0;
  logic hreadyout, hresp, qspi_sclk, qspi_cs_n, erase_in_progress;
  logic [31:0] hrdata;
  logic [3:0] io_out, io_oe, io_in, fl_drive;
  logic [1:0] pad_slew_select, pad_drive_select;
  logic [7:0] fl_opcode;
  int n_mismatch = 0;
  int checks_done = 0;
  always #2 hclk = ~hclk;
  // timer clock runs free and out of phase with hclk
  initial begin
    #7;
    forever #24 slow_clk = ~slow_clk;
  end
  // each lane carries whoever enables it
  assign io_in = (io_oe & io_out) | (~io_oe & fl_drive);
  qepoll_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .erase_cmd_start(erase_cmd_start), .erase_cmd_done(erase_cmd_done),
    .slow_clk(slow_clk), .qspi_sclk(qspi_sclk), .qspi_cs_n(qspi_cs_n),
    .qspi_io_out(io_out), .qspi_io_oe(io_oe), .qspi_io_in(io_in),
    .erase_in_progress(erase_in_progress), .pad_slew_select(pad_slew_select),
    .pad_drive_select(pad_drive_select));
  qepoll_flash_model flash (.qspi_sclk(qspi_sclk), .qspi_cs_n(qspi_cs_n),
    .qspi_io_out(io_out), .tx_mode(cmd[9:8]), .rx_mode(cmd[11:10]),
    .status(fl_status), .opcode(fl_opcode), .drive(fl_drive));
  // ----------
  // bus and compare tasks
  // ----------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask
  // address phase is held until hready is seen high, then the data phase
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rc(input logic [31:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(hrdata, e);
    chk({31'h0, hresp}, 32'h0);
  endtask
  // bounded wait for one frame; t is the wait until select goes low
  task automatic frame(output int t);
    int u;
    t = 0;
    u = 0;
    while (qspi_cs_n !== 1'b0 && t < 2000) begin
      @(posedge hclk);
      t++;
    end
    while (qspi_cs_n !== 1'b1 && u < 2000) begin
      @(posedge hclk);
      u++;
    end
    repeat (2) @(posedge hclk);
  endtask
  task automatic poll(input logic [31:0] c, input logic [7:0] st, input logic ef,
                      input int lo, input int hi);
    int t;
    cmd <= c;
    fl_status <= st;
    wr(`QEP_OFF_CMD, c);
    erase_cmd_start <= 1'b1;
    @(posedge hclk);
    erase_cmd_start <= 1'b0;
    erase_cmd_done <= 1'b1;
    @(posedge hclk);
    erase_cmd_done <= 1'b0;
    frame(t);
    chk(32'(t >= lo && t <= hi), 32'h1);
    chk({24'h0, fl_opcode}, {24'h0, c[7:0]});
    chk({31'h0, erase_in_progress}, {31'h0, ef});
    rc(`QEP_OFF_AUX, {8'h0, st, 7'h0, ef, 2'b00, aux});
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------
  // test sequence
  // ----------
  initial begin
    int t;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({31'h0, erase_in_progress}, 32'h0);
    rc(`QEP_OFF_CMD, 32'h0);
    rc(`QEP_OFF_PAD, 32'h0);
    rc(`QEP_OFF_TRIG, 32'h0);
    wr(`QEP_OFF_CMD, 32'hffffffff);
    rc(`QEP_OFF_CMD, 32'h007fffff);
    wr(`QEP_OFF_PAD, 32'hffffffff);
    rc(`QEP_OFF_PAD, 32'h0000001e);
    wr(`QEP_OFF_PAD, 32'h0000000a);
    // the pad outputs follow the register one edge after the data phase
    @(posedge hclk);
    chk({28'h0, pad_slew_select, pad_drive_select}, 32'h5);
    wr(32'h0c000044, 32'h1);
    rc(32'h0c000044, 32'h0);
    // one lane each way, then mixed lanes with waits on both timers
    poll(32'h000080a5, 8'h01, 1'b1, 0, 4);
    poll(32'h0005f93c, 8'h7f, 1'b0, 40, 80);
    aux <= 6'h3;
    wr(`QEP_OFF_AUX, 32'h3);
    poll(32'h004036c3, 8'hf7, 1'b1, 36, 100);
    // a forced check while erasing sees the flash now idle
    fl_status <= 8'h08;
    wr(`QEP_OFF_TRIG, 32'hdeadbeef);
    frame(t);
    chk({31'h0, erase_in_progress}, 32'h0);
    poll(32'h00005f5a, 8'h20, 1'b0, 0, 4);
    // with no erase under way a trigger write starts no frame
    wr(`QEP_OFF_TRIG, 32'h1);
    frame(t);
    chk(32'(t), 32'd2000);
    complete_run;
  end
  // watchdog well beyond the longest expected run
  initial begin
    #100000;
    n_mismatch++;
    complete_run;
  end
endmodule // qepoll_top_test
